// >>> rtl/mss_params.svh
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define MSS_AW            12
`define MSS_DW            32
`define MSS_WW            24
`define MSS_PAD           8'h00

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MSS_IDX_WORD0     8'h08
`define MSS_IDX_WORD1     8'h09
`define MSS_IDX_CTRL      8'h30

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MSS_RESET_WORD    24'h000000
`define MSS_RESET_CTRL    1'h0
`define MSS_RESET_DATA    32'h00000000

// ----------------------------------------------------------------------
// Matrix geometry: rows and columns sampled by the polling sequencer
// ----------------------------------------------------------------------
`define MSS_ROW10         4'hA
`define MSS_ROW11         4'hB
`define MSS_ROW13         4'hD
`define MSS_ROW14         4'hE
`define MSS_ROW15         4'hF
`define MSS_COL_FIRST     4'h4
`define MSS_COL_LAST      4'h9
`define MSS_COLS          5'h06
`define MSS_ROW11_LSB     5'h06
`define MSS_ROW15_LSB     5'h06

// ----------------------------------------------------------------------
// Common-threshold field in the second word, control bit position
// ----------------------------------------------------------------------
`define MSS_COM_LSB       12
`define MSS_COM_MSB       23
`define MSS_COM_W         12
`define MSS_CTRL_FREEZE   0

`endif

// >>> rtl/mss_pkg.sv
`default_nettype none

package mss_pkg;

    // ------------------------------------------------------------------
    // Types shared by the status bank and its storage
    // ------------------------------------------------------------------
    typedef logic [23:0] mss_word_type;      // One status word

    typedef enum logic [0:0] {
        MSS_ST_IDLE,                         // No transfer in flight
        MSS_ST_ACCESS                        // Access phase of a transfer
    } mss_apb_state_type;

endpackage

`default_nettype wire

// >>> rtl/mss_stat_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_params.svh"

module mss_stat_mem (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire mss_pkg::mss_word_type wr_mask0,
    input  wire mss_pkg::mss_word_type wr_mask1,
    input  wire mss_pkg::mss_word_type wr_data0,
    input  wire mss_pkg::mss_word_type wr_data1,
    input  wire logic                 rd_en,
    input  wire logic                 rd_sel,
    output mss_pkg::mss_word_type     rd_data_q,
    output mss_pkg::mss_word_type     word0_q,
    output mss_pkg::mss_word_type     word1_q
);

    // ------------------------------------------------------------------
    // Storage: each bit is replaced only where its mask is set
    // ------------------------------------------------------------------
    // First word, bits outside the mask hold their last value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word0_q <= `MSS_RESET_WORD;
        end else begin
            word0_q <= (word0_q & ~wr_mask0) | (wr_data0 & wr_mask0);
        end
    end

    // Second word, same merge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word1_q <= `MSS_RESET_WORD;
        end else begin
            word1_q <= (word1_q & ~wr_mask1) | (wr_data1 & wr_mask1);
        end
    end

    // ------------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------------
    // Captured at the setup edge, so it reflects the word before any
    // update landing in that same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_q <= `MSS_RESET_WORD;
        end else if (rd_en) begin
            rd_data_q <= rd_sel ? word1_q : word0_q;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/mss_status_regs.sv
// Notes on behaviour
// R1: word0 bits 11:6 row 11, columns 9..4
// R2: word0 bits 5:0 row 10, columns 9..4
// R3: result bit 1 above, 0 below threshold
// R4: word1 at index 9, read-only, resets zero
// R5: word1 bits 23:12 common flags inputs 11..0
// R6: word1 bits 11:6 row 15, 5:0 row 14
// R7: rows 14, 15 filled by matrix polling
// R8: word0 at index 8, read-only, rows 10-13
// R9: status bits hold between polling updates
`timescale 1ns/1ps
`default_nettype none
`include "mss_params.svh"

module mss_status_regs (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`MSS_AW-1:0]      paddr,
    input  wire logic [`MSS_DW-1:0]      pwdata,
    output logic      [`MSS_DW-1:0]      prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Matrix polling results, one sample per strobe
    input  wire logic                    matrix_valid,
    input  wire logic [3:0]              matrix_row,
    input  wire logic [3:0]              matrix_col,
    input  wire logic                    matrix_above,
    // Common-threshold comparison, all twelve inputs per strobe
    input  wire logic                    common_valid,
    input  wire logic [`MSS_COM_W-1:0]   common_flags
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Byte address of a register index
    function automatic logic [`MSS_AW-1:0] mss_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // True when row and column name a documented result bit
    function automatic logic mss_cell_ok(input logic [3:0] row,
                                         input logic [3:0] col);
        return (row >= `MSS_ROW10) && (row <= `MSS_ROW15) &&
               (col >= `MSS_COL_FIRST) && (col <= `MSS_COL_LAST);
    endfunction

    // Bit position of a cell inside its word: six columns per row,
    // column 4 in the low bit of each group
    function automatic logic [4:0] mss_bit_index(input logic [3:0] row,
                                                 input logic [3:0] col);
        logic [3:0] grp;
        logic [3:0] cof;
        grp = (row >= `MSS_ROW14) ? (row - `MSS_ROW14) : (row - `MSS_ROW10);
        cof = col - `MSS_COL_FIRST;
        return 5'({3'h0, grp[1:0]}) * `MSS_COLS + {1'b0, cof};
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mss_pkg::mss_apb_state_type state_q;     // Transfer phase
    logic                  ctrl_freeze_q;    // Software hold of updates
    logic                  err_q;            // Error answer of this transfer
    logic                  stat_sel_q;       // Read served by storage
    logic [`MSS_DW-1:0]    prdata_q;         // Control read data
    logic                  setup;            // Setup cycle seen
    logic                  access;           // Access phase completes
    logic                  hit_w0;           // Address of first word
    logic                  hit_w1;           // Address of second word
    logic                  hit_ctrl;         // Address of control
    logic                  cell_ok;          // Sample names a real bit
    logic                  cell_hi;          // Sample goes to second word
    logic [4:0]            cell_idx;         // Bit position of sample
    mss_pkg::mss_word_type mask0;            // Update mask, first word
    mss_pkg::mss_word_type mask1;            // Update mask, second word
    mss_pkg::mss_word_type data0;            // Update data, first word
    mss_pkg::mss_word_type data1;            // Update data, second word
    mss_pkg::mss_word_type rd_word;          // Registered storage read
    mss_pkg::mss_word_type word0;            // Live first word
    mss_pkg::mss_word_type word1;            // Live second word

    // ------------------------------------------------------------------
    // Address decode and phase strobes
    // ------------------------------------------------------------------
    assign setup    = psel && !penable;
    // A stray access with no setup before it is never answered
    assign access   = psel && penable && (state_q == mss_pkg::MSS_ST_ACCESS);
    assign hit_w0   = (paddr == mss_addr(`MSS_IDX_WORD0)); // R8
    assign hit_w1   = (paddr == mss_addr(`MSS_IDX_WORD1)); // R4
    assign hit_ctrl = (paddr == mss_addr(`MSS_IDX_CTRL));

    // Zero wait states: the access phase always completes at once
    assign pready  = access;
    assign pslverr = access && err_q;
    // Status reads come from storage, control reads from prdata_q
    assign prdata  = stat_sel_q ? {`MSS_PAD, rd_word} : prdata_q;

    // ------------------------------------------------------------------
    // Transfer phase tracking
    // ------------------------------------------------------------------
    // Follows the master; a setup right after an access is legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= mss_pkg::MSS_ST_IDLE;
        end else begin
            unique case (state_q)
                mss_pkg::MSS_ST_IDLE: begin
                    if (setup) begin
                        state_q <= mss_pkg::MSS_ST_ACCESS;
                    end
                end
                mss_pkg::MSS_ST_ACCESS: begin
                    // Back-to-back setup keeps us in step
                    if (!setup) begin
                        state_q <= mss_pkg::MSS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Answer prepared during the setup cycle
    // ------------------------------------------------------------------
    // Writes to the status words are refused, as are unmapped offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q      <= 1'b0;
            stat_sel_q <= 1'b0;
            prdata_q   <= `MSS_RESET_DATA;
        end else if (setup) begin
            // Status words are read-only
            err_q      <= !(hit_w0 || hit_w1 || hit_ctrl) ||
                          (pwrite && (hit_w0 || hit_w1)); // R4 R8
            stat_sel_q <= !pwrite && (hit_w0 || hit_w1);
            // Unmapped and write cycles read as zero
            if (!pwrite && hit_ctrl) begin
                prdata_q <= {31'h00000000, ctrl_freeze_q};
            end else begin
                prdata_q <= `MSS_RESET_DATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Freeze lets software read both words as one coherent snapshot;
    // the trade-off is that samples arriving while frozen are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_freeze_q <= `MSS_RESET_CTRL;
        end else if (access && pwrite && hit_ctrl) begin
            ctrl_freeze_q <= pwdata[`MSS_CTRL_FREEZE];
        end
    end

    // ------------------------------------------------------------------
    // Update masks from the polling and comparator results
    // ------------------------------------------------------------------
    assign cell_ok  = matrix_valid && !ctrl_freeze_q &&
                      mss_cell_ok(matrix_row, matrix_col);
    assign cell_hi  = (matrix_row >= `MSS_ROW14); // R7
    assign cell_idx = mss_bit_index(matrix_row, matrix_col); // R1 R2 R6

    // Exactly the addressed bits change, everything else holds
    always_comb begin
        mask0 = `MSS_RESET_WORD;
        mask1 = `MSS_RESET_WORD;
        data0 = `MSS_RESET_WORD;
        data1 = `MSS_RESET_WORD;
        // Matrix cell: 1 above threshold, 0 below
        if (cell_ok && !cell_hi) begin
            mask0[cell_idx] = 1'b1; // R1 R2
            data0[cell_idx] = matrix_above; // R3
        end
        if (cell_ok && cell_hi) begin
            mask1[cell_idx] = 1'b1; // R6 R7
            data1[cell_idx] = matrix_above; // R3
        end
        // Common flags: 1 at or above the common threshold
        if (common_valid && !ctrl_freeze_q) begin
            mask1[`MSS_COM_MSB:`MSS_COM_LSB] = {`MSS_COM_W{1'b1}}; // R5
            data1[`MSS_COM_MSB:`MSS_COM_LSB] = common_flags; // R5
        end
    end

    // ------------------------------------------------------------------
    // Status storage
    // ------------------------------------------------------------------
    // Bits without a strobe keep their last value between polls
    mss_stat_mem u_mem ( // R9
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_mask0  (mask0),
        .wr_mask1  (mask1),
        .wr_data0  (data0),
        .wr_data1  (data1),
        .rd_en     (setup && !pwrite),
        .rd_sel    (hit_w1),
        .rd_data_q (rd_word),
        .word0_q   (word0),
        .word1_q   (word1)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_take(logic [3:0] row);
        matrix_valid && !ctrl_freeze_q && matrix_row == row &&
        mss_cell_ok(matrix_row, matrix_col);
    endsequence

    sequence s_rd_setup(logic [7:0] idx);
        psel && !penable && !pwrite && paddr == mss_addr(idx);
    endsequence

    sequence s_done;
        psel && penable && pready;
    endsequence

    property p_row11_cell;
        @(posedge pclk) disable iff (!presetn)
        s_take(`MSS_ROW11) |=>
            word0[`MSS_ROW11_LSB + $past(matrix_col) - `MSS_COL_FIRST] ==
            $past(matrix_above);
    endproperty
    a_row11_cell: assert property (p_row11_cell) // R1
        else $error("row 11 result not stored in its bit");

    property p_row10_cell;
        @(posedge pclk) disable iff (!presetn)
        s_take(`MSS_ROW10) |=>
            word0[$past(matrix_col) - `MSS_COL_FIRST] == $past(matrix_above);
    endproperty
    a_row10_cell: assert property (p_row10_cell) // R2
        else $error("row 10 result not in low bits");

    property p_above_one;
        @(posedge pclk) disable iff (!presetn)
        matrix_valid && !ctrl_freeze_q && matrix_row <= `MSS_ROW13 &&
        mss_cell_ok(matrix_row, matrix_col) && matrix_above |=>
            word0[($past(matrix_row) - `MSS_ROW10) * `MSS_COLS +
                  $past(matrix_col) - `MSS_COL_FIRST];
    endproperty
    a_above_one: assert property (p_above_one) // R3
        else $error("above-threshold sample did not read 1");

    property p_word1_ro;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && pwrite && paddr == mss_addr(`MSS_IDX_WORD1)
        ##1 s_done |-> pslverr;
    endproperty
    a_word1_ro: assert property (p_word1_ro) // R4
        else $error("write to second word not refused");

    property p_common;
        @(posedge pclk) disable iff (!presetn)
        common_valid && !ctrl_freeze_q |=>
            word1[`MSS_COM_MSB:`MSS_COM_LSB] == $past(common_flags);
    endproperty
    a_common: assert property (p_common) // R5
        else $error("common flags not in bits 23:12");

    property p_row15_cell;
        @(posedge pclk) disable iff (!presetn)
        s_take(`MSS_ROW15) |=>
            word1[$past(cell_idx)] == $past(matrix_above) &&
            $past(cell_idx) == `MSS_ROW15_LSB + 5'($past(matrix_col) - `MSS_COL_FIRST);
    endproperty
    a_row15_cell: assert property (p_row15_cell) // R6
        else $error("row 15 result misplaced");

    property p_row14_cell;
        @(posedge pclk) disable iff (!presetn)
        s_take(`MSS_ROW14) |=>
            word1[$past(matrix_col) - `MSS_COL_FIRST] == $past(matrix_above) &&
            $stable(word0);
    endproperty
    a_row14_cell: assert property (p_row14_cell) // R7
        else $error("row 14 result misplaced");

    property p_word0_read;
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(`MSS_IDX_WORD0) ##1 s_done |->
            prdata == {`MSS_PAD, $past(word0)} && !pslverr;
    endproperty
    a_word0_read: assert property (p_word0_read) // R8
        else $error("first word read data wrong");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !matrix_valid && !common_valid |=> $stable(word0) && $stable(word1);
    endproperty
    a_hold: assert property (p_hold) // R9
        else $error("status changed without an update");

endmodule

`default_nettype wire

// >>> sim/mss_sampler.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Far side: polling sequencer and common comparator feeding the bank
// ----------------------------------------------------------------------
module mss_sampler (
    input  wire logic        pclk,
    output logic             matrix_valid,
    output logic [3:0]       matrix_row,
    output logic [3:0]       matrix_col,
    output logic             matrix_above,
    output logic             common_valid,
    output logic [11:0]      common_flags
);
    // Quiet at time zero
    initial begin
        matrix_valid = 1'h0;
        matrix_row   = 4'h0;
        matrix_col   = 4'h0;
        matrix_above = 1'h0;
        common_valid = 1'h0;
        common_flags = 12'h000;
    end

    // One sample per edge; strobes stay up so calls may run back to back
    task automatic put(input logic mv, input logic [3:0] r, input logic [3:0] c,
                       input logic ab, input logic cv, input logic [11:0] cf);
        @(posedge pclk);
        matrix_valid <= mv;
        matrix_row   <= r;
        matrix_col   <= c;
        matrix_above <= ab;
        common_valid <= cv;
        common_flags <= cf;
    endtask

    // Between samples the data lines are not held: invert them so stale
    // values cannot pass for a fresh sample
    task automatic stop();
        @(posedge pclk);
        matrix_valid <= 1'h0;
        common_valid <= 1'h0;
        matrix_row   <= ~matrix_row;
        matrix_col   <= ~matrix_col;
        matrix_above <= ~matrix_above;
        common_flags <= ~common_flags;
    endtask
endmodule

`default_nettype wire

// >>> sim/mss_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_params.svh"

module mss_status_regs_tb;
    // ------------------------------------------------------------------
    // Signals and bench model
    // ------------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic        matrix_valid, matrix_above, common_valid;
    logic [3:0]  matrix_row, matrix_col;
    logic [11:0] common_flags;
    logic [23:0] m0, m1;             // Expected word contents
    logic        mfrz;               // Expected freeze bit
    logic [31:0] rd;
    logic        er;
    int          err_count, checks;
    localparam logic [11:0] addr_w0  = 12'(`MSS_IDX_WORD0 * 4);
    localparam logic [11:0] addr_w1  = 12'(`MSS_IDX_WORD1 * 4);
    localparam logic [11:0] addr_ctl = 12'(`MSS_IDX_CTRL * 4);

    mss_status_regs mss_status_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .matrix_valid(matrix_valid),
        .matrix_row(matrix_row), .matrix_col(matrix_col),
        .matrix_above(matrix_above), .common_valid(common_valid),
        .common_flags(common_flags)
    );

    mss_sampler mss_sampler_inst (
        .pclk(pclk), .matrix_valid(matrix_valid), .matrix_row(matrix_row),
        .matrix_col(matrix_col), .matrix_above(matrix_above),
        .common_valid(common_valid), .common_flags(common_flags)
    );

    // ------------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this is a generous ceiling
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Comparison and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // APB transfer: held until pready is sampled high, bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) chk(32'h0, 32'h1, "no pready");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic xer);
        apb(1'h0, a, 32'h0);
        chk(rd, exp, "read data");
        chk({31'h0, er}, {31'h0, xer}, "read error");
    endtask

    // Sample through the far side and update the model in step
    task automatic smp(input logic [3:0] r, input logic [3:0] c, input logic ab,
                       input logic cv, input logic [11:0] cf);
        int ri, ci;
        ri = r;
        ci = c;
        mss_sampler_inst.put(1'h1, r, c, ab, cv, cf);
        if (!mfrz) begin
            if (ci >= 4 && ci <= 9 && ri >= 10 && ri <= 13) m0[(ri-10)*6+ci-4] = ab;
            if (ci >= 4 && ci <= 9 && ri >= 14 && ri <= 15) m1[(ri-14)*6+ci-4] = ab;
            if (cv) m1[23:12] = cf;
        end
    endtask

    task automatic words_chk();
        rd_chk(addr_w0, {8'h00, m0}, 1'h0);
        rd_chk(addr_w1, {8'h00, m1}, 1'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {m0, m1, mfrz} = 49'h0;
        err_count = 0;
        checks = 0;
        void'($urandom(9925));
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;

        // Reset values and the freeze control
        rd_chk(addr_w0, 32'h0, 1'h0);
        rd_chk(addr_w1, 32'h0, 1'h0);
        rd_chk(addr_ctl, 32'h0, 1'h0);
        $display("test reset done");

        // Writes to status words refused, unmapped read refused
        apb(1'h1, addr_w0, 32'h00FFFFFF);
        chk({31'h0, er}, 32'h1, "w0 write");
        apb(1'h1, addr_w1, 32'h00FFFFFF);
        chk({31'h0, er}, 32'h1, "w1 write");
        rd_chk(12'h028, 32'h0, 1'h1);
        words_chk();
        $display("test refusal done");

        // Every legal row and column plus illegal row 9 and columns 3 and 10, back to back
        for (int p = 0; p < 3; p++) begin
            for (int r = 9; r <= 15; r++) begin
                for (int c = 3; c <= 10; c++) begin
                    smp(4'(r), 4'(c), (p == 0) ? 1'h1 : (p == 2) ? 1'h0 : 1'($urandom),
                        1'($urandom), (p == 0) ? 12'hFFF : (p == 2) ? 12'h000 : 12'($urandom));
                end
            end
            mss_sampler_inst.stop();
            words_chk();
        end
        $display("test matrix done");

        // Single sample lands in its own bit, then holds across idle reads
        smp(4'hB, 4'h7, 1'h1, 1'h1, 12'hA5C);
        mss_sampler_inst.stop();
        rd_chk(addr_w0, 32'h00000200, 1'h0);
        repeat (5) mss_sampler_inst.stop();
        words_chk();
        words_chk();
        $display("test hold done");

        // Frozen bank drops samples, then the freeze bit is cleared
        apb(1'h1, addr_ctl, 32'h1);
        chk({31'h0, er}, 32'h0, "ctl write");
        mfrz = 1'h1;
        rd_chk(addr_ctl, 32'h1, 1'h0);
        smp(4'hA, 4'h4, 1'h1, 1'h1, 12'h0F0);
        smp(4'hF, 4'h9, 1'h1, 1'h0, 12'h000);
        mss_sampler_inst.stop();
        words_chk();
        apb(1'h1, addr_ctl, 32'h0);
        mfrz = 1'h0;
        $display("test freeze done");

        // Random traffic with reads in between
        for (int i = 0; i < 40; i++) begin
            smp(4'(10 + $urandom % 6), 4'(4 + $urandom % 6), 1'($urandom),
                1'($urandom), 12'($urandom));
            if (i % 8 == 7) begin
                mss_sampler_inst.stop();
                words_chk();
            end
        end
        $display("test random done");

        // Reset in mid-run clears every word
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        {m0, m1} = 48'h0;
        words_chk();
        $display("test rereset done");
        complete_run();
    end
endmodule

`default_nettype wire
